// ### hdl/sram_burst_pkg.sv
// Summary of operation
// R1: read select low at K rise latches address
// R2: PLL on: first word 2.5 cycles later
// R3: PLL off: read latency one cycle
// R4: four 18-bit words, lowest first, both edges
// R5: back-to-back read request is ignored
// R6: reads every other cycle stream continuously
// R7: deselected read port finishes, then tristates
// R8: write select low at K rise latches address
// R9: four write words collected into array
// R10: back-to-back write request is ignored
// R11: deselected write port finishes, then ignores inputs
// R12: lane selects sampled per word, mask bytes
// R13: read after write returns newest data
// R14: both selected: read unless last was read
// R15: both held selected: alternate, read first
// R16: selects sampled on K rise only
// R17: inputs and outputs registered on both edges
// R18: impedance recalibration every 1024 cycles
// R19: valid flag leads data by half cycle
// R20: two free-running echo clocks
// R21: PLL lock 100 us after stable clock
// R22: stopping clocks 30 ns resets PLL; code resets only after STALL_CYC (3) system cycles with no heartbeat edge
// R23: lane 0 bits 8:0, lane 1 bits 17:9
// R24: powers up deselected, outputs tristated
// R25: valid flag low outside read bursts
`default_nettype none
package sram_burst_pkg;
    localparam int WORD_W = 18; // one burst word
    localparam int LANE_W = 9; // one byte lane
    localparam int LANES = 2; // active-low selects
    localparam int ADDR_W = 8; // burst address
    localparam int IDX_W = ADDR_W + 2; // word index
    localparam logic [1:0] WORD0 = 2'h0;
    localparam logic [1:0] WORD1 = 2'h1;
    localparam logic [1:0] WORD2 = 2'h2;
    localparam logic [1:0] WORD3 = 2'h3;
    localparam int CLK_SYS_NS = 40; // 25 MHz
    localparam int LOCK_US = 100; // lock time
    localparam int LOCK_CYC = (LOCK_US * 1000 + CLK_SYS_NS - 1)
        / CLK_SYS_NS;
    localparam int PLL_RESET_NS = 30; // clock stop
    localparam int STOP_CYC = (PLL_RESET_NS + CLK_SYS_NS - 1)
        / CLK_SYS_NS;
    // heartbeat toggles once per link period: allow slack
    localparam int STALL_CYC = STOP_CYC + 2;
    localparam int ZQ_PERIOD_CYC = 1024; // recalibration
    // last initiated access, one-hot
    typedef enum logic [2:0] {
        LAST_IDLE = 3'h1,
        LAST_READ = 3'h2,
        LAST_WRITE = 3'h4
    } last_op_e;
    // one burst in flight
    typedef struct packed {
        logic vld;
        logic [ADDR_W-1:0] addr;
    } burst_s;
    // one output word slot
    typedef struct packed {
        logic vld;
        logic [WORD_W-1:0] data;
    } word_s;
endpackage : sram_burst_pkg
`default_nettype wire

// ### hdl/burst_sram_core.sv
`default_nettype none
module burst_sram_core #(
    parameter int LOCK_CYC = sram_burst_pkg::LOCK_CYC,
    parameter int ZQ_CYC = sram_burst_pkg::ZQ_PERIOD_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic k_clk,
    input wire logic read_port_select_n,
    input wire logic write_port_select_n,
    input wire logic [sram_burst_pkg::ADDR_W-1:0] addr,
    input wire logic [sram_burst_pkg::WORD_W-1:0] write_data,
    input wire logic [sram_burst_pkg::LANES-1:0]
        byte_lane_write_select_n,
    input wire logic pll_disable_pin,
    output logic [sram_burst_pkg::WORD_W-1:0] read_data,
    output logic read_drive_n,
    output logic read_valid_flag,
    output logic [1:0] echo_timing_out,
    output logic pll_locked,
    output logic impedance_cal_pulse
);
    localparam int W = sram_burst_pkg::WORD_W;
    localparam int LW = sram_burst_pkg::LANE_W;
    localparam int DEPTH = 2 ** sram_burst_pkg::IDX_W;
    localparam int LOCK_W = $clog2(LOCK_CYC + 1);
    localparam int ZQ_W = $clog2(ZQ_CYC + 1);
    localparam int STALL_W = 4;

    // link-domain reset and mode
    logic rst_meta_q; // first stage only
    logic lrst_q; // link reset
    logic pd_meta_q; // first stage only
    logic pll_on_q; // high: 2.5-cycle mode
    logic hb_q; // link heartbeat toggle

    // access control
    sram_burst_pkg::last_op_e last_q; // last start
    logic rd_req; // read select seen
    logic wr_req; // write select seen
    logic rd_go; // read accepted
    logic wr_go; // write accepted

    // bursts in flight
    sram_burst_pkg::burst_s rs0_q, rs1_q, rs2_q, rs3_q;
    sram_burst_pkg::burst_s ws0_q, ws1_q, ws2_q;

    // storage and negative-edge capture
    logic [W-1:0] mem_q [0:DEPTH-1];
    logic [W-1:0] neg_d_q; // word from K# rise
    logic [sram_burst_pkg::LANES-1:0] neg_bws_q;

    // output slots
    sram_burst_pkg::word_s q_pos_q, q_neg_q;
    sram_burst_pkg::word_s pos_d, neg_d;
    logic rvld_pos_q, rvld_neg_q;
    logic rvld_pos_d, rvld_neg_d;

    // system-domain pll and impedance
    logic hb_meta_q, hb_sync_q, hb_seen_q;
    logic pd_meta_s_q, pd_sync_s_q;
    logic [STALL_W-1:0] stall_cnt_q;
    logic stalled;
    logic [LOCK_W-1:0] lock_cnt_q;
    logic locked_q;
    logic [ZQ_W-1:0] zq_cnt_q;
    logic zq_pulse_q;

    // masked lane merge, lane i owns bits i*9 upward
    function automatic logic [W-1:0] merge_lanes(
        input logic [W-1:0] old_w,
        input logic [W-1:0] new_w,
        input logic [sram_burst_pkg::LANES-1:0] sel_n
    );
        logic [W-1:0] res;
        res = old_w;
        for (int i = 0; i < sram_burst_pkg::LANES; i++) begin
            if (!sel_n[i]) begin // [R12] [R23]
                res[i*LW +: LW] = new_w[i*LW +: LW];
            end
        end
        return res;
    endfunction : merge_lanes

    // reset into the link domain; the device has no pin
    always_ff @(posedge k_clk) begin
        rst_meta_q <= sys_rst;
        lrst_q <= rst_meta_q;
    end

    // mode pin is static but asynchronous to K
    always_ff @(posedge k_clk) begin
        pd_meta_q <= pll_disable_pin;
        pll_on_q <= pd_meta_q;
    end

    // heartbeat lets the system side see K stop
    always_ff @(posedge k_clk) begin
        if (lrst_q) begin
            hb_q <= 1'b0;
        end else begin
            hb_q <= !hb_q;
        end
    end

    // selects sampled on K rise only
    assign rd_req = !read_port_select_n; // [R1] [R16]
    assign wr_req = !write_port_select_n; // [R8] [R16]

    // one start per cycle; history decides the winner
    always_comb begin
        rd_go = 1'b0;
        wr_go = 1'b0;
        case (last_q)
            sram_burst_pkg::LAST_IDLE: begin
                rd_go = rd_req; // [R14] [R15]
                wr_go = wr_req && !rd_req;
            end
            sram_burst_pkg::LAST_READ: begin
                wr_go = wr_req; // second read dropped [R5] [R14]
            end
            sram_burst_pkg::LAST_WRITE: begin
                rd_go = rd_req; // second write dropped [R10] [R14]
            end
            default: begin
                rd_go = 1'b0;
            end
        endcase
    end

    // access history
    always_ff @(posedge k_clk) begin
        if (lrst_q) begin
            last_q <= sram_burst_pkg::LAST_IDLE; // [R24]
        end else if (rd_go) begin
            last_q <= sram_burst_pkg::LAST_READ;
        end else if (wr_go) begin
            last_q <= sram_burst_pkg::LAST_WRITE;
        end else begin
            last_q <= sram_burst_pkg::LAST_IDLE;
        end
    end

    // read bursts age one stage per K rise
    always_ff @(posedge k_clk) begin
        if (lrst_q) begin
            rs0_q <= '0;
            rs1_q <= '0;
            rs2_q <= '0;
            rs3_q <= '0;
        end else begin
            rs0_q.vld <= rd_go;
            rs0_q.addr <= addr; // read address register [R1]
            rs1_q <= rs0_q; // stages finish after deselect [R7]
            rs2_q <= rs1_q;
            rs3_q <= rs2_q;
        end
    end

    // write bursts: stage k owns data of edge k+1
    always_ff @(posedge k_clk) begin
        if (lrst_q) begin
            ws0_q <= '0;
            ws1_q <= '0;
            ws2_q <= '0;
        end else begin
            ws0_q.vld <= wr_go;
            ws0_q.addr <= addr; // write address latched [R8]
            ws1_q <= ws0_q; // pending write completes [R11]
            ws2_q <= ws1_q;
        end
    end

    // data and lane selects on K# rise
    always_ff @(negedge k_clk) begin
        neg_d_q <= write_data; // [R17]
        neg_bws_q <= byte_lane_write_select_n;
    end

    // K-rise words land at once, K# rise words at the next K rise, so a read
    // started next cycle already sees it in the array
    always_ff @(posedge k_clk) begin
        if (ws0_q.vld) begin // [R9]
            mem_q[{ws0_q.addr, sram_burst_pkg::WORD0}] <=
                merge_lanes(mem_q[{ws0_q.addr, sram_burst_pkg::WORD0}],
                    write_data, byte_lane_write_select_n);
        end
        if (ws1_q.vld) begin // [R9] [R13]
            mem_q[{ws1_q.addr, sram_burst_pkg::WORD1}] <=
                merge_lanes(mem_q[{ws1_q.addr, sram_burst_pkg::WORD1}],
                    neg_d_q, neg_bws_q);
            mem_q[{ws1_q.addr, sram_burst_pkg::WORD2}] <=
                merge_lanes(mem_q[{ws1_q.addr, sram_burst_pkg::WORD2}],
                    write_data, byte_lane_write_select_n);
        end
        if (ws2_q.vld) begin // [R9] [R13]
            mem_q[{ws2_q.addr, sram_burst_pkg::WORD3}] <=
                merge_lanes(mem_q[{ws2_q.addr, sram_burst_pkg::WORD3}],
                    neg_d_q, neg_bws_q);
        end
    end

    // word for the next K rise slot
    always_comb begin
        pos_d = '0;
        if (!pll_on_q) begin // one-cycle mode [R3]
            if (rs0_q.vld) begin
                pos_d.vld = 1'b1;
                pos_d.data = mem_q[{rs0_q.addr, sram_burst_pkg::WORD0}];
            end else if (rs1_q.vld) begin
                pos_d.vld = 1'b1;
                pos_d.data = mem_q[{rs1_q.addr, sram_burst_pkg::WORD2}];
            end
        end else begin // 2.5-cycle mode [R2]
            if (rs2_q.vld) begin
                pos_d.vld = 1'b1;
                pos_d.data = mem_q[{rs2_q.addr, sram_burst_pkg::WORD1}];
            end else if (rs3_q.vld) begin
                pos_d.vld = 1'b1;
                pos_d.data = mem_q[{rs3_q.addr, sram_burst_pkg::WORD3}];
            end
        end
    end

    // word for the next K# rise slot
    always_comb begin
        neg_d = '0;
        if (!pll_on_q) begin // [R3] [R4]
            if (rs1_q.vld) begin
                neg_d.vld = 1'b1;
                neg_d.data = mem_q[{rs1_q.addr, sram_burst_pkg::WORD1}];
            end else if (rs2_q.vld) begin
                neg_d.vld = 1'b1;
                neg_d.data = mem_q[{rs2_q.addr, sram_burst_pkg::WORD3}];
            end
        end else begin // [R2] [R4]
            if (rs2_q.vld) begin
                neg_d.vld = 1'b1;
                neg_d.data = mem_q[{rs2_q.addr, sram_burst_pkg::WORD0}];
            end else if (rs3_q.vld) begin
                neg_d.vld = 1'b1;
                neg_d.data = mem_q[{rs3_q.addr, sram_burst_pkg::WORD2}];
            end
        end
    end

    // valid flag looks one slot ahead of the data
    always_comb begin
        if (pll_on_q) begin // [R19]
            rvld_pos_d = rs1_q.vld || rs2_q.vld;
            rvld_neg_d = rs2_q.vld || rs3_q.vld;
        end else begin
            rvld_pos_d = rs0_q.vld || rs1_q.vld;
            rvld_neg_d = rs0_q.vld || rs1_q.vld;
        end
    end

    // K rise output registers
    always_ff @(posedge k_clk) begin
        if (lrst_q) begin
            q_pos_q <= '0; // [R24]
            rvld_pos_q <= 1'b0;
        end else begin
            q_pos_q <= pos_d; // [R17] [R6]
            rvld_pos_q <= rvld_pos_d; // [R25]
        end
    end

    // K# rise output registers
    always_ff @(negedge k_clk) begin
        if (lrst_q) begin
            q_neg_q <= '0;
            rvld_neg_q <= 1'b0;
        end else begin
            q_neg_q <= neg_d; // [R17] [R6]
            rvld_neg_q <= rvld_neg_d; // [R25]
        end
    end

    // phase mux: each register owns its half cycle; an empty
    // slot releases the bus, so a deselect goes quiet [R7]
    assign read_data = k_clk ? q_pos_q.data : q_neg_q.data;
    assign read_drive_n = k_clk ? !q_pos_q.vld : !q_neg_q.vld;
    assign read_valid_flag = k_clk ? rvld_pos_q : rvld_neg_q;
    assign echo_timing_out = {!k_clk, k_clk}; // [R20]

    // link heartbeat and mode pin into the system domain
    always_ff @(posedge clk_sys) begin
        hb_meta_q <= hb_q;
        hb_sync_q <= hb_meta_q;
        hb_seen_q <= hb_sync_q;
        pd_meta_s_q <= pll_disable_pin;
        pd_sync_s_q <= pd_meta_s_q;
    end

    // clock-stop watch: no heartbeat edge for a while [R22]
    always_ff @(posedge clk_sys) begin
        if (sys_rst || (hb_sync_q != hb_seen_q)) begin
            stall_cnt_q <= '0;
        end else if (!stalled) begin
            stall_cnt_q <= stall_cnt_q + STALL_W'(1);
        end
    end
    assign stalled = stall_cnt_q >= STALL_W'(sram_burst_pkg::STALL_CYC);

    // lock timer restarts on any clock disturbance
    always_ff @(posedge clk_sys) begin
        if (sys_rst || stalled || !pd_sync_s_q) begin
            lock_cnt_q <= '0; // [R21]
            locked_q <= 1'b0;
        end else if (lock_cnt_q == LOCK_W'(LOCK_CYC - 1)) begin
            locked_q <= 1'b1; // [R21]
        end else begin
            lock_cnt_q <= lock_cnt_q + LOCK_W'(1);
        end
    end
    assign pll_locked = locked_q;

    // periodic impedance update strobe
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            zq_cnt_q <= '0;
            zq_pulse_q <= 1'b0;
        end else if (zq_cnt_q == ZQ_W'(ZQ_CYC - 1)) begin
            zq_cnt_q <= '0; // [R18]
            zq_pulse_q <= 1'b1;
        end else begin
            zq_cnt_q <= zq_cnt_q + ZQ_W'(1);
            zq_pulse_q <= 1'b0;
        end
    end
    assign impedance_cal_pulse = zq_pulse_q;

    property p_rd_no_back;
        @(posedge k_clk) disable iff (lrst_q) rd_go |=> !rd_go;
    endproperty
    a_rd_no_back: assert property (p_rd_no_back) // [R5]
        else $error("read accepted on consecutive K rises");

    property p_wr_no_back;
        @(posedge k_clk) disable iff (lrst_q) wr_go |=> !wr_go;
    endproperty
    a_wr_no_back: assert property (p_wr_no_back) // [R10]
        else $error("write accepted on consecutive K rises");

    property p_arb_idle;
        @(posedge k_clk) disable iff (lrst_q)
            (rd_req && wr_req && last_q == sram_burst_pkg::LAST_IDLE)
            |-> rd_go ##1 wr_go;
    endproperty
    a_arb_idle: assert property (p_arb_idle) // [R15]
        else $error("idle contention did not start read then write");

    property p_arb_after_rd;
        @(posedge k_clk) disable iff (lrst_q)
            ($past(rd_go) && rd_req && wr_req) |-> (wr_go && !rd_go);
    endproperty
    a_arb_after_rd: assert property (p_arb_after_rd) // [R14]
        else $error("write lost arbitration after a read");

    property p_lat_on;
        @(posedge k_clk) disable iff (lrst_q)
            (rd_go && pll_on_q) |-> ##3 q_neg_q.vld
            ##1 (q_pos_q.vld && q_neg_q.vld) ##1 q_pos_q.vld;
    endproperty
    a_lat_on: assert property (p_lat_on) // [R2]
        else $error("burst timing wrong in 2.5-cycle mode");

    property p_lat_off;
        @(posedge k_clk) disable iff (lrst_q)
            (rd_go && !pll_on_q) |-> ##2 (q_pos_q.vld && q_neg_q.vld)
            ##1 (q_pos_q.vld && q_neg_q.vld);
    endproperty
    a_lat_off: assert property (p_lat_off) // [R3]
        else $error("burst timing wrong in one-cycle mode");

    property p_deselect;
        @(posedge k_clk) disable iff (lrst_q)
            (!rd_go) [*6] |=> (!q_pos_q.vld && !q_neg_q.vld);
    endproperty
    a_deselect: assert property (p_deselect) // [R7]
        else $error("read port still driving after deselect");

    property p_valid_lead;
        @(posedge k_clk) disable iff (lrst_q)
            q_pos_q.vld == $past(rvld_neg_q);
    endproperty
    a_valid_lead: assert property (p_valid_lead) // [R19]
        else $error("valid flag not half a cycle ahead");

    property p_valid_tail;
        @(posedge k_clk) disable iff (lrst_q)
            rvld_pos_q == q_neg_q.vld;
    endproperty
    a_valid_tail: assert property (p_valid_tail) // [R25]
        else $error("valid flag outside the data window");

    property p_wr_pipe;
        @(posedge k_clk) disable iff (lrst_q)
            wr_go |=> ws0_q.vld ##1 ws1_q.vld ##1 ws2_q.vld;
    endproperty
    a_wr_pipe: assert property (p_wr_pipe) // [R9]
        else $error("write burst did not run four words");

    property p_lock_drop;
        @(posedge clk_sys) disable iff (sys_rst)
            stalled |=> !locked_q;
    endproperty
    a_lock_drop: assert property (p_lock_drop) // [R21]
        else $error("lock held across a stopped clock");

endmodule : burst_sram_core
`default_nettype wire

// ### tb/link_ctrl_model.sv
`default_nettype none
// memory controller on the far side of the link
module link_ctrl_model (
    input wire logic k_clk,
    output logic read_port_select_n,
    output logic write_port_select_n,
    output logic [sram_burst_pkg::ADDR_W-1:0] addr,
    output logic [sram_burst_pkg::WORD_W-1:0] write_data,
    output logic [sram_burst_pkg::LANES-1:0] byte_lane_write_select_n,
    output int half_idx
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [19:0] slot_q [int]; // lanes and word, keyed by edge number
    // quiet link at power up
    initial begin
        read_port_select_n = 1'h1;
        write_port_select_n = 1'h1;
        addr = '0;
        write_data = '0;
        byte_lane_write_select_n = 2'h3;
        half_idx = 0;
    end
    // every edge launches what the following edge samples
    always @(posedge k_clk or negedge k_clk) begin
        half_idx <= half_idx + 1;
        if (slot_q.exists(half_idx + 2)) begin
            // staged word with its own lane selects
            {byte_lane_write_select_n, write_data} <=
                slot_q[half_idx + 2];
        end else begin
            // no data phase: bus keeps moving, never stale
            write_data <= ~write_data;
            byte_lane_write_select_n <= ~byte_lane_write_select_n;
        end
    end
    // one request slot; s returns the edge number that samples it
    task automatic req(input logic rd_n, input logic wr_n,
            input logic [sram_burst_pkg::ADDR_W-1:0] a, output int s);
        @(posedge k_clk);
        read_port_select_n <= rd_n;
        write_port_select_n <= wr_n;
        addr <= (rd_n & wr_n) ? ~addr : a; // idle address wanders
        s = half_idx + 3;
    endtask : req
    // four words after the sampling rise, lowest first
    function automatic void stage(input int s, input logic [71:0] d,
            input logic [7:0] ln);
        for (int k = 0; k < 4; k++) begin
            slot_q[s + 2 + k] = {ln[2*k +: 2], d[18*k +: 18]};
        end
    endfunction : stage
endmodule : link_ctrl_model
`default_nettype wire

// ### tb/burst_sram_core_tb.sv
`default_nettype none
module burst_sram_core_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef logic [sram_burst_pkg::ADDR_W-1:0] addr_t;
    typedef logic [sram_burst_pkg::WORD_W-1:0] word_t;
    localparam int LOCK_T = 20; // short lock count
    localparam int ZQ_T = 16; // short recalibration period
    logic clk_sys = 1'h0;
    logic k_clk = 1'h0;
    logic k_run = 1'h1; // cleared to stall the link clock
    logic sys_rst = 1'h1;
    logic pll_disable_pin = 1'h1; // pll on first
    logic rps_n;
    logic wps_n;
    addr_t addr;
    word_t wdata;
    logic [1:0] lanes_n;
    word_t read_data;
    logic read_drive_n;
    logic read_valid_flag;
    logic [1:0] echo;
    logic pll_locked;
    logic cal_pulse;
    int half_idx;
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;
    int zq_last = 0;
    int zq_gap = 0;
    int lat = 5; // half cycles from request to first word
    logic [1:0] last_q = 2'h0; // 0 idle, 1 read, 2 write
    logic mon_on = 1'h0;
    logic vld_prev = 1'h0;
    int exp_h[$]; // edge number of each expected word
    word_t exp_d[$];
    word_t mem [logic [9:0]]; // bench copy of the array

    always #20 clk_sys = ~clk_sys;
    // link clock, free running unless stalled on purpose
    always #24 if (k_run) k_clk = ~k_clk;

    burst_sram_core #(.LOCK_CYC(LOCK_T), .ZQ_CYC(ZQ_T)) burst_sram_core_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .k_clk(k_clk),
        .read_port_select_n(rps_n), .write_port_select_n(wps_n),
        .addr(addr), .write_data(wdata),
        .byte_lane_write_select_n(lanes_n),
        .pll_disable_pin(pll_disable_pin), .read_data(read_data),
        .read_drive_n(read_drive_n), .read_valid_flag(read_valid_flag),
        .echo_timing_out(echo), .pll_locked(pll_locked),
        .impedance_cal_pulse(cal_pulse));

    link_ctrl_model link_ctrl_model_i (
        .k_clk(k_clk), .read_port_select_n(rps_n),
        .write_port_select_n(wps_n), .addr(addr), .write_data(wdata),
        .byte_lane_write_select_n(lanes_n), .half_idx(half_idx));

    task automatic chk_word(input word_t got, input word_t exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t word %h not %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t flag %b not %b", $time, got, exp);
        end
    endtask : chk_bit
    task automatic chk_num(input int got, input int exp);
        checked++;
        if (got != exp) begin
            n_errors++;
            $display("BAD %0t count %0d not %0d", $time, got, exp);
        end
    endtask : chk_num
    task automatic conclude();
        if (n_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude

    // which start the device takes at a rise
    function automatic logic [1:0] grant(input logic r, input logic w,
            input logic [1:0] last);
        if (!r && last != 2'h1) return 2'h1;
        if (!w && last != 2'h2) return 2'h2;
        return 2'h0;
    endfunction : grant
    // lane select low replaces that lane only
    function automatic word_t merge(input word_t o, input word_t n,
            input logic [1:0] ln);
        merge = o;
        if (!ln[0]) merge[8:0] = n[8:0];
        if (!ln[1]) merge[17:9] = n[17:9];
    endfunction : merge
    function automatic logic [71:0] rnd();
        return {8'($urandom), $urandom, $urandom};
    endfunction : rnd

    // one request slot; expectations follow the arbitration
    task automatic op(input logic r, input logic w, input addr_t a,
            input logic [71:0] d, input logic [7:0] ln);
        int s;
        logic [1:0] g;
        link_ctrl_model_i.req(r, w, a, s);
        g = grant(r, w, last_q);
        last_q = g;
        if (g == 2'h2) link_ctrl_model_i.stage(s, d, ln);
        for (int k = 0; k < 4; k++) begin
            if (g == 2'h1) begin
                exp_h.push_back(s + lat + k);
                exp_d.push_back(mem[{a, 2'(k)}]);
            end
            if (g == 2'h2) mem[{a, 2'(k)}] =
                merge(mem[{a, 2'(k)}], d[18*k +: 18], ln[2*k +: 2]);
        end
    endtask : op
    task automatic wr(input addr_t a, input logic [71:0] d,
            input logic [7:0] ln);
        op(1'h1, 1'h0, a, d, ln);
    endtask : wr
    task automatic rd(input addr_t a);
        op(1'h0, 1'h1, a, rnd(), 8'hFF);
    endtask : rd
    task automatic idle(input int n);
        repeat (n) op(1'h1, 1'h1, '0, rnd(), 8'hFF);
    endtask : idle
    // random writes, each read back after a gap
    task automatic mix(input int n);
        addr_t a;
        repeat (n) begin
            a = addr_t'(8'h20 + $urandom_range(3));
            wr(a, rnd(), 8'($urandom));
            idle(1);
            rd(a);
            idle(2);
        end
    endtask : mix
    task automatic wait_lock(input int lo);
        int n;
        for (n = 0; n < 60 && pll_locked !== 1'h1; n++) @(negedge clk_sys);
        chk_num(int'(n >= lo && n <= LOCK_T + 8), 1);
        if (n == 60) conclude();
    endtask : wait_lock
    task automatic drain();
        int n;
        for (n = 0; n < 40 && exp_h.size() > 0; n++) @(posedge k_clk);
        if (n == 40) begin
            chk_num(exp_h.size(), 0);
            conclude();
        end
    endtask : drain

    // calibration pulse spacing in system cycles
    always @(negedge clk_sys) begin
        cyc++;
        if (cal_pulse === 1'h1) begin
            zq_gap = cyc - zq_last;
            zq_last = cyc;
        end
    end
    // look mid half cycle, away from both edges
    always @(k_clk) begin
        #12;
        if (mon_on) begin
            chk_bit(echo[0], k_clk);
            chk_bit(echo[1], ~k_clk);
            chk_bit(vld_prev, ~read_drive_n);
            vld_prev = read_valid_flag;
            if (read_drive_n === 1'h0) begin
                // an unasked word fails on both counts
                chk_num(half_idx, exp_h.size() ? exp_h.pop_front() : -1);
                chk_word(read_data,
                    exp_d.size() ? exp_d.pop_front() : ~read_data);
            end else if (exp_h.size() && exp_h[0] <= half_idx) begin
                // expected word never driven
                chk_num(-1, exp_h.pop_front());
                void'(exp_d.pop_front());
            end
        end
    end

    initial begin
        void'($urandom(32'h39CC));
        repeat (4) @(negedge clk_sys);
        chk_bit(read_drive_n, 1'h1);
        chk_bit(read_valid_flag, 1'h0);
        sys_rst = 1'h0;
        wait_lock(LOCK_T - 2);
        mon_on = 1'h1;
        for (int i = 0; i < 4; i++) begin
            wr(addr_t'(8'h20 + i), rnd(), 8'h00);
            idle(1);
        end
        wr(8'h21, rnd(), 8'hC6);
        idle(1);
        rd(8'h21);
        wr(8'h22, rnd(), 8'h00);
        rd(8'h22);
        idle(1);
        wr(8'h23, rnd(), 8'h00);
        wr(8'h23, rnd(), 8'h00);
        idle(1);
        rd(8'h23);
        idle(1);
        rd(8'h20);
        rd(8'h21);
        rd(8'h22);
        idle(1);
        rd(8'h23);
        idle(2);
        // both selects held from idle
        for (int i = 0; i < 6; i++) begin
            op(1'h0, 1'h0, addr_t'(i[0] ? 8'h40 + i : 8'h20 + i / 2),
                rnd(), 8'h00);
        end
        idle(2);
        for (int i = 1; i < 6; i += 2) begin
            rd(addr_t'(8'h40 + i));
            idle(1);
        end
        mix(10);
        drain();
        k_run = 1'h0;
        repeat (10) @(negedge clk_sys);
        chk_bit(pll_locked, 1'h0);
        k_run = 1'h1;
        wait_lock(LOCK_T - 2);
        pll_disable_pin = 1'h0;
        repeat (10) @(negedge clk_sys);
        chk_bit(pll_locked, 1'h0);
        lat = 2;
        mix(6);
        drain();
        chk_num(zq_gap, ZQ_T);
        conclude();
    end
endmodule : burst_sram_core_tb
`default_nettype wire
